// ---- inc/sweep_list_pkg.sv ----
package sweep_list_pkg;
   // ************************************************************
   // Sizes and register map
   // ************************************************************
   localparam int IDX_W = 9;                       // Entry index width
   localparam logic [8:0] MAX_ENTRIES = 9'h1F4;    // List capacity
   localparam logic [7:0] ADDR_CMD = 8'h00;        // Command word
   localparam logic [7:0] ADDR_START_ID = 8'h04;   // Start identifier
   localparam logic [7:0] ADDR_ITER = 8'h08;       // Repeat count
   localparam logic [7:0] ADDR_STATUS = 8'h0C;     // Run and error flags
   localparam logic [7:0] ADDR_COUNT = 8'h10;      // Entries held
   localparam logic [7:0] ADDR_STOP_IDX = 8'h14;   // Index at stop
   localparam logic [7:0] ADDR_F_START = 8'h18;    // Staging start freq
   localparam logic [7:0] ADDR_F_STOP = 8'h1C;     // Staging stop freq
   localparam logic [7:0] ADDR_F_STEP = 8'h20;     // Staging step
   localparam logic [7:0] ADDR_DWELL = 8'h24;      // Staging dwell and trigger
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CMD_OP_LSB = 0;                  // Opcode, 4 bits
   localparam int CMD_ID_BIT = 4;                  // Start carries an ID
   localparam int CMD_IDX_LSB = 16;                // Index, 9 bits, 0 = none
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_ERR_BIT = 1;                // Write one to clear
   localparam int STAT_BUSY_BIT = 2;
   localparam int DWELL_TRIG_BIT = 16;
   // ************************************************************
   // Command opcodes
   // ************************************************************
   localparam logic [3:0] OP_NEW = 4'h1;
   localparam logic [3:0] OP_COPY = 4'h2;
   localparam logic [3:0] OP_SAVE = 4'h3;
   localparam logic [3:0] OP_DEL = 4'h4;
   localparam logic [3:0] OP_DEL_ALL = 4'h5;
   localparam logic [3:0] OP_START = 4'h6;
   localparam logic [3:0] OP_STOP = 4'h7;
   localparam logic [3:0] OP_ABORT = 4'h8;
   localparam logic [3:0] OP_OTHER = 4'h9;         // Any non-sweep command
   // ************************************************************
   // Reset and default values
   // ************************************************************
   localparam logic [31:0] ITER_RST = 32'h0000_0000;
   localparam logic [31:0] START_ID_RST = 32'h0000_0000;
   localparam logic [31:0] DEF_F_START = 32'h0000_0000;
   localparam logic [31:0] DEF_F_STOP = 32'h0000_0000;
   localparam logic [31:0] DEF_F_STEP = 32'h0000_0000;
   localparam logic [15:0] DEF_DWELL = 16'h0064;   // Dwell in clock cycles
   // One list entry
   typedef struct packed {
      logic [31:0] fstart;
      logic [31:0] fstop;
      logic [31:0] fstep;
      logic [15:0] dwell;
      logic trig;
   } entry_t;
   localparam entry_t DEF_ENTRY = '{DEF_F_START, DEF_F_STOP, DEF_F_STEP, DEF_DWELL, 1'b0};
   // Engine and list edit states
   typedef enum logic [2:0] {E_IDLE, E_CTX, E_LOAD, E_TRIG, E_CAP} eng_t;
   typedef enum logic [1:0] {ED_IDLE, ED_UP, ED_DN} ed_t;
endpackage

// ---- design/sweep_list_sequencer.sv ----
// Behaviour
// - List holds at most 500 entries.
// - Entries addressed, inserted, deleted by index.
// - Staging joins list only on save.
// - New loads staging defaults, adds nothing.
// - Triggered entry outputs data after trigger.
// - Dwell expiry skips to next entry.
// - Full buffer pauses engine until space.
// - End on repeat count, abort or stop.
// - Sweep pushes packets without host requests.
// - Stopped keeps last settings, accepts others.
// - Restart applies settings from entries.
// - Running rejects non-sweep commands with error.
// - Sweep settings writable while running.
// - Repeat count 32 bits, 0 forever, reset 0.
// - Start runs list from first entry.
// - Start emits context packet first, with identifier if ID bit set, else zero.
// - Status shows running or stopped, stopped after reset.
// - Stop halts and records stop index.
// - Copy loads staging from valid index, else error.
// - Count query returns entries held.
// - Delete one or all, indices shift down.
// - Entry holds single frequency or stepped range.
// - Indexed save inserts, plain save appends.
module sweep_list_sequencer (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Packet stream to host
   output logic pkt_valid_o,
   output logic pkt_ctx_o,
   output logic [31:0] pkt_data_o,
   input wire logic pkt_ready_i,
   // Capture front end
   input wire logic trig_i,
   input wire logic [31:0] cap_data_i,
   output logic [31:0] cur_freq_o,
   output logic running_o,
   output logic nonsweep_exec_o
);
   import sweep_list_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      eng_t eng;
      ed_t ed;
      logic [IDX_W-1:0] count;      // Entries held
      logic [IDX_W-1:0] ptr;        // Shift pointer
      logic [IDX_W-1:0] ins_idx;    // Insert slot
      logic [IDX_W-1:0] cur_idx;    // Entry being run, zero based
      logic [IDX_W-1:0] stop_idx;   // One based index at stop
      logic [31:0] iter;
      logic [31:0] pass_cnt;
      logic [31:0] start_id;
      entry_t st;                   // Staging entry
      logic [15:0] dwell_cnt;
      logic [31:0] cur_freq;
      logic running;
      logic err;
      logic stop_req;               // Stop after packet completes
      logic nonsweep_exec;
      logic pkt_valid;
      logic pkt_ctx;
      logic [31:0] pkt_data;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } state_t;

   state_t state_reg, state_next;
   entry_t mem [0:MAX_ENTRIES-1];   // Sweep list storage
   logic mem_we;
   logic [IDX_W-1:0] mem_wa;
   entry_t mem_wd;
   logic [IDX_W-1:0] rd_addr;
   entry_t rd_a;                    // Entry at edit or copy pointer
   entry_t rd_cur;                  // Entry under execution
   logic cmd_fire;
   logic [3:0] cmd_op;
   logic [IDX_W-1:0] cmd_idx;
   logic adv;
   logic stop_now;
   logic err_set;

   // Safe list read
   function automatic entry_t mem_rd(input logic [IDX_W-1:0] a);
      return (a < MAX_ENTRIES) ? mem[a] : DEF_ENTRY;
   endfunction

   // Decoded address is mapped
   function automatic logic addr_ok(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= ADDR_DWELL);
   endfunction

   // Another centre frequency fits in the range
   function automatic logic step_more(input logic [31:0] f, input entry_t e);
      return (e.fstep != 32'h0) && ({1'b0, f} + {1'b0, e.fstep} <= {1'b0, e.fstop});
   endfunction

   // ************************************************************
   // Command decode and list reads
   // ************************************************************
   assign cmd_fire = psel_i && penable_i && pwrite_i && state_reg.pready && paddr_i == ADDR_CMD;
   assign cmd_op = pwdata_i[CMD_OP_LSB +: 4];
   assign cmd_idx = pwdata_i[CMD_IDX_LSB +: IDX_W];
   // Process form so that list writes wake the reads
   always_comb rd_cur = mem_rd(state_reg.cur_idx);
   always_comb rd_a = mem_rd(rd_addr);

   // Read pointer for shifts and copy
   always_comb begin
      case (state_reg.ed)
         ED_UP: rd_addr = state_reg.ptr - 9'h001;
         ED_DN: rd_addr = state_reg.ptr + 9'h001;
         default: rd_addr = cmd_idx - 9'h001;
      endcase
   end

   // List write port, one slot per cycle
   always_comb begin
      mem_we = 1'b0;
      mem_wa = state_reg.ptr;
      mem_wd = rd_a;
      case (state_reg.ed)
         ED_UP: begin
            mem_we = 1'b1;
            if (state_reg.ptr == state_reg.ins_idx) begin
               mem_wd = state_reg.st;
            end
         end
         ED_DN: mem_we = (state_reg.ptr + 9'h001) < state_reg.count;
         default: mem_we = 1'b0;
      endcase
   end

   // List storage
   always_ff @(posedge clk_i) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic [31:0] rdata;
      logic [IDX_W-1:0] k;
      rdata = 32'h0;
      k = 9'h000;
      state_next = state_reg;
      adv = 1'b0;
      stop_now = 1'b0;
      err_set = 1'b0;
      state_next.nonsweep_exec = 1'b0;
      // APB answer, one wait-free access phase
      state_next.pready = psel_i && !penable_i;
      state_next.pslverr = 1'b0;
      if (psel_i && !penable_i) begin
         case (paddr_i)
            ADDR_START_ID: rdata = state_reg.start_id;
            ADDR_ITER: rdata = state_reg.iter;
            ADDR_STATUS: begin
               rdata[STAT_RUN_BIT] = state_reg.running;
               rdata[STAT_ERR_BIT] = state_reg.err;
               rdata[STAT_BUSY_BIT] = state_reg.ed != ED_IDLE;
            end
            ADDR_COUNT: rdata = {23'h0, state_reg.count};
            ADDR_STOP_IDX: rdata = {23'h0, state_reg.stop_idx};
            ADDR_F_START: rdata = state_reg.st.fstart;
            ADDR_F_STOP: rdata = state_reg.st.fstop;
            ADDR_F_STEP: rdata = state_reg.st.fstep;
            ADDR_DWELL: rdata = {15'h0, state_reg.st.trig, state_reg.st.dwell};
            default: rdata = 32'h0;
         endcase
         state_next.prdata = rdata;
         state_next.pslverr = !addr_ok(paddr_i);
      end
      // Register writes, allowed while running
      if (psel_i && penable_i && pwrite_i && state_reg.pready) begin
         case (paddr_i)
            ADDR_START_ID: state_next.start_id = pwdata_i;
            ADDR_ITER: state_next.iter = pwdata_i;
            ADDR_STATUS: begin
               if (pwdata_i[STAT_ERR_BIT]) begin
                  state_next.err = 1'b0;
               end
            end
            ADDR_F_START: state_next.st.fstart = pwdata_i;
            ADDR_F_STOP: state_next.st.fstop = pwdata_i;
            ADDR_F_STEP: state_next.st.fstep = pwdata_i;
            ADDR_DWELL: begin
               state_next.st.dwell = pwdata_i[15:0];
               state_next.st.trig = pwdata_i[DWELL_TRIG_BIT];
            end
            default: ;
         endcase
      end
      // List shifting
      case (state_reg.ed)
         ED_UP: begin
            if (state_reg.ptr == state_reg.ins_idx) begin
               state_next.count = state_reg.count + 9'h001;
               state_next.ed = ED_IDLE;
            end else begin
               state_next.ptr = state_reg.ptr - 9'h001;
            end
         end
         ED_DN: begin
            if ((state_reg.ptr + 9'h001) >= state_reg.count) begin
               state_next.count = state_reg.count - 9'h001;
               state_next.ed = ED_IDLE;
            end else begin
               state_next.ptr = state_reg.ptr + 9'h001;
            end
         end
         default: state_next.ed = ED_IDLE;
      endcase
      // Sweep engine
      case (state_reg.eng)
         E_IDLE: ;
         // Context packet ahead of any data
         E_CTX: begin
            if (pkt_ready_i) begin
               state_next.pkt_valid = 1'b0;
               if (state_reg.count == 9'h000) begin
                  stop_now = 1'b1;
               end else begin
                  state_next.eng = E_LOAD;
               end
            end
         end
         // Apply entry settings
         E_LOAD: begin
            state_next.cur_freq = rd_cur.fstart;
            state_next.dwell_cnt = rd_cur.dwell;
            state_next.eng = rd_cur.trig ? E_TRIG : E_CAP;
         end
         // Wait for trigger within dwell
         E_TRIG: begin
            if (trig_i) begin
               state_next.eng = E_CAP;
            end else if (state_reg.dwell_cnt == 16'h0000) begin
               adv = 1'b1;
            end else begin
               state_next.dwell_cnt = state_reg.dwell_cnt - 16'h0001;
            end
         end
         // Push one data packet per centre frequency
         E_CAP: begin
            if (!state_reg.pkt_valid) begin
               state_next.pkt_valid = 1'b1;
               state_next.pkt_ctx = 1'b0;
               state_next.pkt_data = cap_data_i;
            end else if (pkt_ready_i) begin
               // Word taken once the host buffer has space
               state_next.pkt_valid = 1'b0;
               if (state_reg.stop_req) begin
                  stop_now = 1'b1;
               end else if (step_more(state_reg.cur_freq, rd_cur)) begin
                  state_next.cur_freq = state_reg.cur_freq + rd_cur.fstep;
               end else begin
                  adv = 1'b1;
               end
            end
         end
         default: state_next.eng = E_IDLE;
      endcase
      // Next entry, pass counting and wrap
      if (adv) begin
         if ((state_reg.cur_idx + 9'h001) >= state_reg.count) begin
            if (state_reg.iter != 32'h0 && (state_reg.pass_cnt + 32'h1) == state_reg.iter) begin
               stop_now = 1'b1;
            end else begin
               state_next.pass_cnt = state_reg.pass_cnt + 32'h1;
               state_next.cur_idx = 9'h000;
               state_next.eng = E_LOAD;
            end
         end else begin
            state_next.cur_idx = state_reg.cur_idx + 9'h001;
            state_next.eng = E_LOAD;
         end
      end
      // Halt, settings of last entry kept
      if (stop_now) begin
         state_next.eng = E_IDLE;
         state_next.running = 1'b0;
         state_next.stop_req = 1'b0;
         state_next.stop_idx = state_reg.cur_idx + 9'h001;
      end
      // Commands
      if (cmd_fire) begin
         if (state_reg.ed != ED_IDLE) begin
            err_set = 1'b1;
         end else begin
            case (cmd_op)
               OP_NEW: state_next.st = DEF_ENTRY;
               OP_COPY: begin
                  if (cmd_idx == 9'h000 || cmd_idx > state_reg.count) begin
                     err_set = 1'b1;
                  end else begin
                     state_next.st = rd_a;
                  end
               end
               OP_SAVE: begin
                  k = (cmd_idx == 9'h000) ? state_reg.count + 9'h001 : cmd_idx;
                  if (state_reg.count >= MAX_ENTRIES || k > state_reg.count + 9'h001) begin
                     err_set = 1'b1;
                  end else begin
                     state_next.ptr = state_reg.count;
                     state_next.ins_idx = k - 9'h001;
                     state_next.ed = ED_UP;
                  end
               end
               OP_DEL: begin
                  if (cmd_idx == 9'h000 || cmd_idx > state_reg.count) begin
                     err_set = 1'b1;
                  end else begin
                     state_next.ptr = cmd_idx - 9'h001;
                     state_next.ed = ED_DN;
                  end
               end
               OP_DEL_ALL: state_next.count = 9'h000;
               OP_START: begin
                  state_next.running = 1'b1;
                  state_next.eng = E_CTX;
                  state_next.cur_idx = 9'h000;
                  state_next.pass_cnt = 32'h0;
                  state_next.stop_req = 1'b0;
                  state_next.pkt_valid = 1'b1;
                  state_next.pkt_ctx = 1'b1;
                  state_next.pkt_data = pwdata_i[CMD_ID_BIT] ? state_reg.start_id : START_ID_RST;
               end
               OP_STOP: begin
                  // Word still pending: finish it first
                  if (state_reg.eng == E_CAP && state_reg.pkt_valid && !pkt_ready_i) begin
                     state_next.stop_req = 1'b1;
                  end else if (state_reg.running) begin
                     state_next.eng = E_IDLE;
                     state_next.running = 1'b0;
                     state_next.pkt_valid = 1'b0;
                     state_next.stop_idx = state_reg.cur_idx + 9'h001;
                  end
               end
               OP_ABORT: begin
                  state_next.eng = E_IDLE;
                  state_next.running = 1'b0;
                  state_next.stop_req = 1'b0;
                  state_next.pkt_valid = 1'b0;
                  state_next.stop_idx = state_reg.cur_idx + 9'h001;
               end
               OP_OTHER: begin
                  if (state_reg.running) begin
                     err_set = 1'b1;
                  end else begin
                     state_next.nonsweep_exec = 1'b1;
                  end
               end
               default: err_set = 1'b1;
            endcase
         end
      end
      // Set wins over software clear
      if (err_set) begin
         state_next.err = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_reg <= '0;
         state_reg.eng <= E_IDLE;
         state_reg.ed <= ED_IDLE;
         state_reg.iter <= ITER_RST;
         state_reg.start_id <= START_ID_RST;
         state_reg.st <= DEF_ENTRY;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs
   assign prdata_o = state_reg.prdata;
   assign pready_o = state_reg.pready;
   assign pslverr_o = state_reg.pslverr;
   assign pkt_valid_o = state_reg.pkt_valid;
   assign pkt_ctx_o = state_reg.pkt_ctx;
   assign pkt_data_o = state_reg.pkt_data;
   assign cur_freq_o = state_reg.cur_freq;
   assign running_o = state_reg.running;
   assign nonsweep_exec_o = state_reg.nonsweep_exec;

   // ************************************************************
   // Assertions
   // ************************************************************
   property p_max_count;
      @(posedge clk_i) disable iff (!rst_n_i) state_reg.count <= MAX_ENTRIES;
   endproperty
   a_max_count: assert property (p_max_count) else $error("list above capacity");

   property p_full_refuse;
      @(posedge clk_i) disable iff (!rst_n_i)
      cmd_fire && cmd_op == OP_SAVE && state_reg.count == MAX_ENTRIES |=> state_reg.ed == ED_IDLE;
   endproperty
   a_full_refuse: assert property (p_full_refuse) else $error("save into full list");

   property p_new_defaults;
      @(posedge clk_i) disable iff (!rst_n_i)
      cmd_fire && cmd_op == OP_NEW && state_reg.ed == ED_IDLE
      |=> state_reg.st == DEF_ENTRY && $stable(state_reg.count);
   endproperty
   a_new_defaults: assert property (p_new_defaults) else $error("new entry wrong");

   property p_ctx_first;
      @(posedge clk_i) disable iff (!rst_n_i)
      cmd_fire && cmd_op == OP_START && state_reg.ed == ED_IDLE
      |=> pkt_valid_o && pkt_ctx_o && state_reg.eng == E_CTX;
   endproperty
   a_ctx_first: assert property (p_ctx_first) else $error("no context packet");

   property p_reject;
      @(posedge clk_i) disable iff (!rst_n_i)
      cmd_fire && cmd_op == OP_OTHER && running_o |=> state_reg.err && !nonsweep_exec_o;
   endproperty
   a_reject: assert property (p_reject) else $error("non-sweep command taken");

   property p_stall;
      @(posedge clk_i) disable iff (!rst_n_i)
      pkt_valid_o && !pkt_ready_i && !cmd_fire |=> pkt_valid_o && $stable(pkt_data_o);
   endproperty
   a_stall: assert property (p_stall) else $error("packet lost under stall");

   property p_timeout;
      @(posedge clk_i) disable iff (!rst_n_i)
      state_reg.eng == E_TRIG && !trig_i && state_reg.dwell_cnt == 16'h0000 && !cmd_fire
      |=> state_reg.eng == E_LOAD || state_reg.eng == E_IDLE;
   endproperty
   a_timeout: assert property (p_timeout) else $error("dwell expiry ignored");

   property p_reset_stopped;
      @(posedge clk_i) disable iff (!rst_n_i) $rose(rst_n_i) |-> !running_o;
   endproperty
   a_reset_stopped: assert property (p_reset_stopped) else $error("running after reset");

   property p_copy_err;
      @(posedge clk_i) disable iff (!rst_n_i)
      cmd_fire && cmd_op == OP_COPY && state_reg.count == 9'h000 |=> state_reg.err;
   endproperty
   a_copy_err: assert property (p_copy_err) else $error("copy from empty list");

   property p_iter_end;
      @(posedge clk_i) disable iff (!rst_n_i)
      adv && !cmd_fire && state_reg.iter != 32'h0 && (state_reg.cur_idx + 9'h001) >= state_reg.count
      && (state_reg.pass_cnt + 32'h1) == state_reg.iter |=> !running_o;
   endproperty
   a_iter_end: assert property (p_iter_end) else $error("sweep ran past count");

   c_start: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(running_o));
   c_trig_timeout: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      state_reg.eng == E_TRIG && state_reg.dwell_cnt == 16'h0000 && !trig_i);
   c_stall: cover property (@(posedge clk_i) disable iff (!rst_n_i) pkt_valid_o && !pkt_ready_i);
   c_insert: cover property (@(posedge clk_i) disable iff (!rst_n_i) state_reg.ed == ED_UP);
endmodule // sweep_list_sequencer

// ---- dv/pkt_host_model.sv ----
module pkt_host_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Packet stream
   input wire logic pkt_valid_i,
   input wire logic pkt_ctx_i,
   input wire logic [31:0] pkt_data_i,
   output logic pkt_ready_o,
   // Tallies for the bench
   output logic [15:0] n_ctx_o,
   output logic [15:0] n_dat_o,
   output logic [31:0] last_id_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cyc_reg; // Stall pattern phase
   // Host buffer full one cycle in four, so the engine must pause
   assign pkt_ready_o = (cyc_reg != 2'h3);
   // ************************************************************
   // Take words pushed without any request
   // ************************************************************
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         cyc_reg <= 2'h0;
         n_ctx_o <= 16'h0000;
         n_dat_o <= 16'h0000;
         last_id_o <= 32'hFFFF_FFFF;
      end else begin
         cyc_reg <= cyc_reg + 2'h1;
         if (pkt_valid_i && pkt_ready_o && pkt_ctx_i) begin
            n_ctx_o <= n_ctx_o + 16'h0001; // Context word
            last_id_o <= pkt_data_i;
         end else if (pkt_valid_i && pkt_ready_o) begin
            n_dat_o <= n_dat_o + 16'h0001; // Data word
         end
      end
   end
endmodule // pkt_host_model

// ---- dv/sweep_list_sequencer_tb_top.sv ----
module sweep_list_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import sweep_list_pkg::*;
   logic clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, pkt_data_o, cur_freq_o, rd, last_id;
   logic pready_o, pslverr_o, pkt_valid_o, pkt_ctx_o, pkt_ready_i, running_o, nonsweep_exec_o;
   logic er, trig_i = 1'b0;
   logic [15:0] n_ctx, n_dat;
   int n_errors = 0, tests_run = 0, cycles = 0, n_exec = 0;
   always #50 clk_i = ~clk_i;
   // Timeout and pulse tally
   always @(posedge clk_i) begin
      cycles++;
      if (nonsweep_exec_o === 1'b1) n_exec++;
      if (cycles == 30000) begin
         n_errors++;
         finish_test();
      end
   end
   sweep_list_sequencer sweep_list_sequencer_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .pkt_valid_o(pkt_valid_o), .pkt_ctx_o(pkt_ctx_o), .pkt_data_o(pkt_data_o),
      .pkt_ready_i(pkt_ready_i), .trig_i(trig_i), .cap_data_i(32'h0000_1234),
      .cur_freq_o(cur_freq_o), .running_o(running_o), .nonsweep_exec_o(nonsweep_exec_o));
   pkt_host_model pkt_host_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .pkt_valid_i(pkt_valid_o), .pkt_ctx_i(pkt_ctx_o), .pkt_data_i(pkt_data_o),
      .pkt_ready_o(pkt_ready_i), .n_ctx_o(n_ctx), .n_dat_o(n_dat), .last_id_o(last_id));
   // One APB transfer, held until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rd = prdata_o; er = pslverr_o;
      psel_i <= 1'b0; penable_i <= 1'b0;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Poll a status bit until it reads the given value
   task poll(input int b, input logic v);
      do apb(1'b0, ADDR_STATUS, 32'h0); while (rd[b] !== v);
   endtask
   task cmd(input logic [3:0] op, input logic [8:0] idx, input logic idb);
      apb(1'b1, ADDR_CMD, {7'h00, idx, 11'h000, idb, op});
      poll(STAT_BUSY_BIT, 1'b0);
   endtask
   task t_reset_edit;
      apb(1'b0, ADDR_STATUS, 32'h0); chk(rd, 32'h0);
      apb(1'b0, ADDR_ITER, 32'h0); chk(rd, ITER_RST);
      apb(1'b0, 8'h28, 32'h0); chk({31'h0, er}, 32'h1);
      cmd(OP_COPY, 9'h001, 1'b0);
      apb(1'b0, ADDR_STATUS, 32'h0); chk(rd[STAT_ERR_BIT], 1'b1);
      apb(1'b1, ADDR_STATUS, 32'h2);
      apb(1'b1, ADDR_DWELL, 32'h7); cmd(OP_NEW, 9'h000, 1'b0);
      apb(1'b0, ADDR_DWELL, 32'h0); chk(rd, {15'h0, 1'b0, DEF_DWELL});
      apb(1'b0, ADDR_COUNT, 32'h0); chk(rd, 32'h0);
   endtask
   task t_build_run;
      cmd(OP_SAVE, 9'h000, 1'b0); cmd(OP_SAVE, 9'h001, 1'b0);
      apb(1'b1, ADDR_F_START, 32'hA); apb(1'b1, ADDR_F_STOP, 32'h1E);
      apb(1'b1, ADDR_F_STEP, 32'hA); cmd(OP_SAVE, 9'h000, 1'b0);
      apb(1'b0, ADDR_COUNT, 32'h0); chk(rd, 32'h3);
      apb(1'b1, ADDR_ITER, 32'h1); apb(1'b1, ADDR_START_ID, 32'h5A);
      cmd(OP_START, 9'h000, 1'b1);
      poll(STAT_RUN_BIT, 1'b0);
      chk(last_id, 32'h5A); chk({16'h0, n_ctx}, 32'h1);
      chk({16'h0, n_dat}, 32'h5);
      chk(cur_freq_o, 32'h1E);
      apb(1'b0, ADDR_STOP_IDX, 32'h0); chk(rd, 32'h3);
   endtask
   task t_forever;
      apb(1'b1, ADDR_ITER, 32'h0); cmd(OP_START, 9'h000, 1'b0);
      repeat (200) @(posedge clk_i);
      apb(1'b1, ADDR_CMD, {28'h0, OP_OTHER});
      apb(1'b0, ADDR_STATUS, 32'h0); chk(rd[1:0], 2'h3);
      chk(n_exec, 0); chk(last_id, 32'h0);
      cmd(OP_STOP, 9'h000, 1'b0); poll(STAT_RUN_BIT, 1'b0);
      chk({31'h0, running_o}, 32'h0);
      apb(1'b1, ADDR_CMD, {28'h0, OP_OTHER}); repeat (2) @(posedge clk_i);
      chk(n_exec, 1);
   endtask
   task t_delete;
      cmd(OP_DEL, 9'h001, 1'b0); apb(1'b0, ADDR_COUNT, 32'h0); chk(rd, 32'h2);
      cmd(OP_COPY, 9'h002, 1'b0);
      apb(1'b0, ADDR_F_START, 32'h0);
      chk(rd, 32'hA);
      apb(1'b1, ADDR_STATUS, 32'h2);
      repeat (498) cmd(OP_SAVE, 9'h000, 1'b0);
      apb(1'b0, ADDR_COUNT, 32'h0);
      chk(rd, {23'h0, MAX_ENTRIES});
      cmd(OP_SAVE, 9'h000, 1'b0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[STAT_ERR_BIT], 1'b1);
      cmd(OP_DEL_ALL, 9'h000, 1'b0); apb(1'b0, ADDR_COUNT, 32'h0); chk(rd, 32'h0);
   endtask
   // Trigger wait, dwell expiry and abort
   task t_trigger;
      logic [15:0] n0;
      cmd(OP_NEW, 9'h000, 1'b0);
      apb(1'b1, ADDR_DWELL, 32'h0001_0005);
      cmd(OP_SAVE, 9'h000, 1'b0);
      apb(1'b1, ADDR_ITER, 32'h2);
      n0 = n_dat;
      cmd(OP_START, 9'h000, 1'b0);
      poll(STAT_RUN_BIT, 1'b0);
      chk({16'h0, n_dat - n0}, 32'h0);
      trig_i <= 1'b1;
      cmd(OP_START, 9'h000, 1'b0);
      poll(STAT_RUN_BIT, 1'b0);
      chk({16'h0, n_dat - n0}, 32'h2);
      apb(1'b1, ADDR_ITER, 32'h0);
      cmd(OP_START, 9'h000, 1'b0);
      cmd(OP_ABORT, 9'h000, 1'b0);
      chk({31'h0, running_o}, 32'h0);
   endtask
   task finish_test;
      $display("errors %0d comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset_edit();
      t_build_run();
      t_forever();
      t_delete();
      t_trigger();
      finish_test();
   end
endmodule // sweep_list_sequencer_tb_top
